/* File: bench/sec_host.sv */
/*
 sec_host: behavioural serial host for the eeprom front end, mode 0.
 Assumes the bench calls frame() from one process only.
*/
`timescale 1ns/1ps
module sec_host (
	input  wire logic mclk,
	input  wire logic so,
	input  wire logic so_oe,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      hold_n
);
	initial begin
		cs_n   = 1'b1;
		sck    = 1'b0;
		si     = 1'b0;
		hold_n = 1'b1;
	end

	// hp > 0 pauses before bit hp, clocking noise into the held link
	task automatic frame(input int n, input logic [127:0] tx, input int hp,
			output logic [127:0] rx, output logic oe, output logic hb);
		rx = '0;
		oe = 1'b0;
		hb = 1'b0;
		@(negedge mclk);
		cs_n = 1'b0;
		for (int i = 0; i < n * 8; i++) begin
			si = tx[127 - i];
			if (i == hp && hp > 0) begin
				hold_n = 1'b0;
				repeat (3) begin
					#3 sck = 1'b1;
					si = ~si;
					if (so_oe !== 1'b0)
						hb = 1'b1;
					#3 sck = 1'b0;
				end
				hold_n = 1'b1;
				si = tx[127 - i];
			end
			// sample just before the rise, so never races the link logic
			// a floating line reads as noise, never as the last bit
			#3 rx = {rx[126:0], so_oe ? so : ~so};
			oe = oe | so_oe;
			sck = 1'b1;
			#3 sck = 1'b0;
		end
		#3 cs_n = 1'b1;
		si = ~si; // released line must not keep its last value
		rx = rx << (128 - n * 8);
		repeat (5) @(negedge mclk);
	endtask
endmodule // sec_host

/* File: bench/tb.sv */
/*
 tb: self-checking bench for sec_core through its serial pins.
 Assumes sec_host drives the link and PROG_CYC is shortened to 40.
*/
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] RD = sec_pkg::OP_READ;
	localparam logic [7:0] WR = sec_pkg::OP_WRITE;
	localparam logic [7:0] SW = sec_pkg::OP_STAT_WR;
	logic         mclk, nrst, cs_n, sck, si, so, so_oe, wp_n, hold_n, standby;
	logic [127:0] rx;
	logic         oe, hb;
	logic [7:0]   s;
	int           fails, checked;

	sec_core #(.PROG_CYC(40)) sec_core_inst (.mclk(mclk), .nrst(nrst), .cs_n(cs_n),
		.sck(sck), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n),
		.standby(standby));
	sec_host sec_host_inst (.mclk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n),
		.sck(sck), .si(si), .hold_n(hold_n));

	always #5 mclk = ~mclk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] bt(input int k);
		return rx[127 - 8 * k -: 8];
	endfunction

	task automatic xf(input int n, input logic [127:0] tx, input int hp);
		sec_host_inst.frame(n, tx, hp, rx, oe, hb);
	endtask

	task automatic cmd(input logic [7:0] op);
		xf(1, {op, 120'h0}, 0);
	endtask

	task automatic stat;
		xf(2, {sec_pkg::OP_STAT_RD, 120'h0}, 0);
		s = bt(1);
	endtask

	// bounded poll: a write that never finishes shows up as busy here
	task automatic idle;
		int k;
		k = 0;
		stat;
		while (s[0] !== 1'b0 && k < 50) begin
			stat;
			k++;
		end
		chk(s & 8'h01, 8'h00);
	endtask

	task automatic end_of_test;
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		end_of_test;
	end

	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		wp_n = 1'b1;
		fails = 0;
		checked = 0;
		repeat (6) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		chk({7'h00, standby}, 8'h01);
		chk({7'h00, so_oe}, 8'h00);
		stat;
		chk(s, 8'h00);
		xf(5, {RD, 16'hFFFF, 104'h0}, 0);
		chk(bt(3), 8'hFF);
		chk(bt(4), 8'hFF);
		chk({7'h00, oe}, 8'h01);
		cmd(8'hAB);
		xf(4, {8'hAB, 120'h0}, 0);
		chk({7'h00, oe}, 8'h00);
		xf(4, {WR, 24'h0101_A5, 96'h0}, 0);
		stat;
		chk(s, 8'h00);
		cmd(sec_pkg::OP_SET_WL);
		stat;
		chk(s, 8'h02);
		cmd(sec_pkg::OP_CLR_WL);
		stat;
		chk(s, 8'h00);
		cmd(sec_pkg::OP_SET_WL);
		xf(5, {WR, 32'h8101_A55A, 88'h0}, 0);
		chk({7'h00, standby}, 8'h00);
		stat;
		chk(s, 8'h03);
		xf(4, {RD, 16'h0100, 104'h0}, 0);
		chk({7'h00, oe}, 8'h00);
		idle;
		stat;
		chk(s, 8'h00);
		sec_core_inst.mem[13'h0040] = sec_core_inst.mem[13'h0040] ^ 38'h00_0000_0100;
		xf(7, {RD, 16'h0100, 104'h0}, 44);
		chk({7'h00, hb}, 8'h00);
		chk(bt(3), 8'hFF);
		chk(bt(4), 8'hA5);
		chk(bt(5), 8'h5A);
		chk(bt(6), 8'hFF);
		cmd(sec_pkg::OP_SET_WL);
		xf(2, {SW, 8'h8C, 112'h0}, 0);
		idle;
		stat;
		chk(s, 8'h8C);
		cmd(sec_pkg::OP_SET_WL);
		xf(4, {WR, 24'h0101_00, 96'h0}, 0);
		stat;
		chk(s & 8'hFD, 8'h8C);
		xf(4, {RD, 16'h0101, 104'h0}, 0);
		chk(bt(3), 8'hA5);
		@(negedge mclk) wp_n = 1'b0;
		cmd(sec_pkg::OP_SET_WL);
		xf(2, {SW, 8'h00, 112'h0}, 0);
		stat;
		chk(s & 8'hFC, 8'h8C);
		@(negedge mclk) wp_n = 1'b1;
		cmd(sec_pkg::OP_SET_WL);
		xf(2, {SW, 8'h04, 112'h0}, 0);
		idle;
		cmd(sec_pkg::OP_SET_WL);
		xf(7, {WR, 16'h6000, 32'h1122_3344, 72'h0}, 0);
		stat;
		chk(s, 8'h06);
		xf(7, {WR, 16'h4000, 32'h1122_3344, 72'h0}, 0);
		idle;
		xf(7, {RD, 16'h4000, 104'h0}, 0);
		chk(bt(3), 8'h11);
		chk(bt(4), 8'h22);
		chk(bt(6), 8'h44);
		xf(4, {RD, 16'h6000, 104'h0}, 0);
		chk(bt(3), 8'hFF);
		cmd(sec_pkg::OP_SET_WL);
		xf(2, {SW, 8'h00, 112'h0}, 0);
		idle;
		stat;
		chk(s, 8'h00);
		chk({7'h00, standby}, 8'h01);
		end_of_test;
	end
endmodule // tb

/* File: rtl/sec_core.sv */
/*
 sec_core: serial eeprom slave front end with ecc-protected array,
 page buffer and timed programming. The link logic is clocked by sck;
 programming by mclk. Assumes sck stands still while cs_n is
 high, so the link state is stable when the core commits a frame.
*/
// How it works
// R1: deselected means output floats, pins ignored
// R2: idle and deselected is standby
// R3: host drops select before first instruction
// R4: input sampled at sck rising edge
// R5: output changes after sck falling edge
// R6: host keeps write protect pin defined
// R7: pause freezes transfer, resumes where stopped
// R8: paused means output floats, pins ignored
// R9: host holds select low while paused
// R10: delivered array reads all ones
// R11: delivered lock and guard bits zero
// R12: six check bits per four-byte group
// R13: reads correct one bad bit per group
// R14: any write reprograms whole group plus checks
// R15: host should rewrite whole groups
// R16: frame starts at select fall, msb first
// R17: one-byte opcodes, latch ops stand alone
// R18: unknown opcode drops rest of frame
// R19: status read repeats status byte
// R20: status write takes one byte
// R21: two address bytes, top bit ignored
// R22: read streams incrementing addresses from clock 25
// R23: write latch gates writes, cleared after
// R24: busy bit high only while programming
// R25: guard bits protect area, lock blocks status
// R26: page of data, commit at byte boundary
// R27: programming ends within bounded time
`timescale 1ns/1ps
module sec_core #(
	parameter int PROG_CYC = sec_pkg::PROGRAM_CYC
) (
	input  logic mclk,
	input  logic nrst,
	input  logic cs_n,
	input  logic sck,
	input  logic si,
	output logic so,
	output logic so_oe,
	input  logic wp_n,
	input  logic hold_n,
	output logic standby
);
	typedef enum logic [1:0] {S_IDLE, S_MERGE, S_WAIT} sec_state_e;

	typedef struct packed {
		logic [7:0]                  sh;
		logic [7:0]                  cmd;
		logic [2:0]                  ph;
		logic [2:0]                  nb;
		logic [sec_pkg::ADDR_W-1:0]  addr;
		logic [7:0]                  osh;
		logic [7:0]                  stat_new;
		logic                        dead;
		logic [63:0]                 mask;
		logic                        busy_m;
		logic                        busy_s;
		logic                        wl_m;
		logic                        wl_s;
	} sec_link_s;

	typedef struct packed {
		logic                        cs_m;
		logic                        cs_s;
		logic                        cs_d;
		logic                        wp_m;
		logic                        wp_s;
		logic                        write_latch_flag;
		logic                        busy;
		sec_state_e                  st;
		logic [sec_pkg::TMR_W-1:0]   tmr;
		logic [sec_pkg::GRP_W-1:0]   grp;
		logic [sec_pkg::PAGE_W-1:0]  page;
		logic                        stat_op;
		logic                        lock;
		logic [1:0]                  bg;
		logic [2:0]                  new_st;
	} sec_core_s;

	sec_link_s   l;
	sec_link_s   next_l;
	sec_core_s   c;
	sec_core_s   next_c;
	logic        fresh;
	logic [2:0]  f_ph;
	logic [2:0]  f_nb;
	logic        f_dead;
	logic [63:0] f_mask;
	logic [7:0]  sh_in;
	logic [7:0]  stat_byte;
	logic        buf_we;
	logic        rise;
	logic        guarded;
	logic        mem_we;
	logic [12:0] mem_wa;
	logic [37:0] mem_wd;
	logic [7:0]  pbuf [64];
	logic [37:0] mem [sec_pkg::WORDS];

	// hamming code over 38 positions; syn picks the data bit to flip
	function automatic logic [37:0] ham(input logic [31:0] d, input logic [5:0] syn);
		logic [5:0]  p;
		logic [31:0] f;
		int          i;
		p = '0;
		f = d;
		i = 0;
		for (int pos = 3; pos < 39; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (d[i])
					p = p ^ pos[5:0];
				if (syn == pos[5:0])
					f[i] = ~d[i];
				i++;
			end
		end
		return {p, f};
	endfunction

	function automatic logic [31:0] ecc_fix(input logic [37:0] w);
		logic [37:0] g;
		g = ham(w[31:0], 6'h00);
		g = ham(w[31:0], g[37:32] ^ w[37:32]); // see R13
		return g[31:0];
	endfunction

	function automatic logic [7:0] rd_byte(input logic [14:0] a);
		logic [31:0] w;
		w = ecc_fix(mem[a[14:2]]);
		return w[{a[1:0], 3'b000} +: 8];
	endfunction

	function automatic logic op_known(input logic [7:0] op);
		return op == sec_pkg::OP_SET_WL || op == sec_pkg::OP_CLR_WL ||
			op == sec_pkg::OP_STAT_RD || op == sec_pkg::OP_STAT_WR ||
			op == sec_pkg::OP_READ || op == sec_pkg::OP_WRITE; // see R17
	endfunction

	// array as delivered: erased words with matching check bits
	initial begin
		for (int k = 0; k < sec_pkg::WORDS; k++)
			mem[k] = ham(sec_pkg::ERASED_WORD, 6'h00); // see R10 R12
	end

	// plain always: the array also takes its delivered content at time zero
	always @(posedge mclk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	// set by deselect, so each frame restarts at bit zero
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n)
			fresh <= 1'b1;
		else
			fresh <= fresh & ~hold_n; // see R3 R16
	end

	assign f_ph   = fresh ? 3'h0 : l.ph;
	assign f_nb   = fresh ? 3'h0 : l.nb;
	assign f_dead = fresh ? 1'b0 : l.dead;
	assign f_mask = fresh ? 64'h0000_0000_0000_0000 : l.mask;
	assign sh_in  = {l.sh[6:0], si}; // see R4 R16

	always_comb begin
		stat_byte                    = 8'h00;
		stat_byte[sec_pkg::ST_LOCK]  = c.lock;
		stat_byte[sec_pkg::ST_BG_HI] = c.bg[1];
		stat_byte[sec_pkg::ST_BG_LO] = c.bg[0];
		stat_byte[sec_pkg::ST_WL]    = l.wl_s;
		stat_byte[sec_pkg::ST_BUSY]  = l.busy_s;
	end

	always_comb begin
		next_l        = l;
		next_l.busy_m = c.busy;
		next_l.busy_s = l.busy_m;
		next_l.wl_m   = c.write_latch_flag;
		next_l.wl_s   = l.wl_m;
		buf_we        = 1'b0;
		// a paused or dropped frame keeps its state untouched
		if (hold_n && !f_dead) begin // see R7
			next_l.sh   = sh_in;
			next_l.ph   = f_ph + 3'h1;
			next_l.nb   = f_nb;
			next_l.dead = 1'b0;
			next_l.mask = f_mask;
			next_l.osh  = {l.osh[6:0], 1'b0};
			if (f_ph == 3'h7) begin
				if (f_nb != sec_pkg::NB_DATA)
					next_l.nb = f_nb + 3'h1;
				case (f_nb)
				3'h0: begin
					next_l.cmd  = sh_in;
					next_l.dead = !op_known(sh_in) || // see R18
						(sh_in == sec_pkg::OP_READ && l.busy_s) ||
						((sh_in == sec_pkg::OP_WRITE ||
						sh_in == sec_pkg::OP_STAT_WR) && !l.wl_s); // see R23
					next_l.osh  = stat_byte; // see R19
				end
				3'h1: begin
					next_l.stat_new   = sh_in; // see R20
					next_l.addr[14:8] = sh_in[6:0]; // see R21
					next_l.osh        = stat_byte;
				end
				3'h2: begin
					next_l.addr[7:0] = sh_in;
					if (l.cmd == sec_pkg::OP_STAT_RD)
						next_l.osh = stat_byte;
					else
						next_l.osh = rd_byte({l.addr[14:8], sh_in}); // see R22
				end
				default: begin
					if (l.cmd == sec_pkg::OP_WRITE) begin
						// column wraps inside the page
						buf_we                   = 1'b1;
						next_l.mask[l.addr[5:0]] = 1'b1; // see R26
						next_l.addr[5:0]         = l.addr[5:0] + 6'h01;
					end else if (l.cmd == sec_pkg::OP_READ) begin
						next_l.addr = l.addr + 15'h0001; // see R22
						next_l.osh  = rd_byte(l.addr + 15'h0001);
					end else begin
						next_l.osh = stat_byte; // see R19
					end
				end
				endcase
			end
		end
	end

	always_ff @(posedge sck or negedge nrst) begin
		if (!nrst)
			l <= '0;
		else
			l <= next_l;
	end

	always_ff @(posedge sck) begin
		if (buf_we)
			pbuf[l.addr[5:0]] <= sh_in;
	end

	always_ff @(negedge sck or negedge nrst) begin
		if (!nrst)
			so <= 1'b0;
		else
			so <= l.osh[7]; // see R5
	end

	assign so_oe = !cs_n && hold_n && !fresh && !l.dead && // see R1 R8 R9
		((l.cmd == sec_pkg::OP_STAT_RD && l.nb != 3'h0) ||
		(l.cmd == sec_pkg::OP_READ && l.nb >= sec_pkg::NB_HDR));

	assign rise    = c.cs_s && !c.cs_d;
	assign standby = c.cs_s && !c.busy; // see R2

	always_comb begin
		case (c.bg)
		2'b01:   guarded = l.addr[14:13] == 2'b11; // see R25
		2'b10:   guarded = l.addr[14];
		2'b11:   guarded = 1'b1;
		default: guarded = 1'b0;
		endcase
	end

	// the link state is read at commit, and l.mask on each of the 16 merge cycles after it
	always_comb begin
		logic [31:0] w;
		w           = ecc_fix(mem[{c.page, c.grp}]);
		next_c      = c;
		next_c.cs_m = cs_n;
		next_c.cs_s = c.cs_m;
		next_c.cs_d = c.cs_s;
		next_c.wp_m = wp_n; // see R6
		next_c.wp_s = c.wp_m;
		mem_we      = 1'b0;
		mem_wa      = {c.page, c.grp};
		for (int b = 0; b < 4; b++) begin
			if (l.mask[{c.grp, b[1:0]}])
				w[b*8 +: 8] = pbuf[{c.grp, b[1:0]}]; // see R14
		end
		mem_wd = ham(w, 6'h00); // see R12
		case (c.st)
		S_IDLE: begin
			if (rise && l.ph == 3'h0 && !l.dead) begin // see R26
				case (l.cmd)
				sec_pkg::OP_SET_WL: begin
					if (l.nb == sec_pkg::NB_CTRL)
						next_c.write_latch_flag = 1'b1; // see R17 R23
				end
				sec_pkg::OP_CLR_WL: begin
					if (l.nb == sec_pkg::NB_CTRL)
						next_c.write_latch_flag = 1'b0; // see R23
				end
				sec_pkg::OP_STAT_WR: begin
					if (l.nb == sec_pkg::NB_STAT && c.write_latch_flag && !(c.lock && !c.wp_s)) begin
						next_c.busy    = 1'b1; // see R24 R25
						next_c.st      = S_WAIT;
						next_c.stat_op = 1'b1;
						next_c.tmr     = '0;
						next_c.new_st  = {l.stat_new[7], l.stat_new[3:2]};
					end
				end
				sec_pkg::OP_WRITE: begin
					if (l.nb == sec_pkg::NB_DATA && c.write_latch_flag && !guarded) begin
						next_c.busy    = 1'b1; // see R24
						next_c.st      = S_MERGE;
						next_c.stat_op = 1'b0;
						next_c.tmr     = '0;
						next_c.grp     = '0;
						next_c.page    = l.addr[14:6];
					end
				end
				default: ;
				endcase
			end
		end
		S_MERGE: begin
			// one group per cycle; untouched groups are rewritten as read
			mem_we     = 1'b1; // see R14
			next_c.tmr = c.tmr + 20'h0_0001;
			next_c.grp = c.grp + 4'h1;
			if (c.grp == 4'hF)
				next_c.st = S_WAIT;
		end
		S_WAIT: begin
			next_c.tmr = c.tmr + 20'h0_0001;
			if (c.tmr >= sec_pkg::TMR_W'(PROG_CYC - 1)) begin // see R27
				next_c.busy = 1'b0;
				next_c.write_latch_flag  = 1'b0; // see R23
				next_c.st   = S_IDLE;
				if (c.stat_op) begin
					next_c.lock = c.new_st[2]; // see R25
					next_c.bg   = c.new_st[1:0];
				end
			end
		end
		default: next_c.st = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			c <= '{cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, st: S_IDLE, default: '0}; // see R11
		else
			c <= next_c;
	end

	a_deselect_float: assert property (@(posedge mclk) disable iff (!nrst) // see R1
		cs_n |-> !so_oe) else $error("output driven while deselected");

	a_hold_float: assert property (@(posedge mclk) disable iff (!nrst) // see R8
		!hold_n |-> !so_oe) else $error("output driven while paused");

	a_standby_idle: assert property (@(posedge mclk) disable iff (!nrst) // see R2
		c.st != S_IDLE |-> !standby) else $error("standby while programming");

	a_latch_needed: assert property (@(posedge mclk) disable iff (!nrst) // see R23
		$rose(c.busy) |-> $past(c.write_latch_flag)) else $error("write without latch");

	a_latch_cleared: assert property (@(posedge mclk) disable iff (!nrst) // see R23
		$fell(c.busy) |-> !c.write_latch_flag) else $error("latch left set after write");

	a_busy_bounded: assert property (@(posedge mclk) disable iff (!nrst) // see R27
		c.busy |-> c.tmr < sec_pkg::TMR_W'(PROG_CYC)) else $error("write overran");

	a_merge_groups: assert property (@(posedge mclk) disable iff (!nrst) // see R14
		$rose(c.st == S_MERGE) |-> (c.st == S_MERGE)[*8] ##1 (c.st == S_MERGE)[*8]
		##1 c.st == S_WAIT) else $error("group rewrite count wrong");

	a_lock_blocks: assert property (@(posedge mclk) disable iff (!nrst) // see R25
		rise && c.st == S_IDLE && l.cmd == sec_pkg::OP_STAT_WR && c.lock && !c.wp_s
		|=> !c.busy) else $error("locked status was written");

	a_hold_freeze: assert property (@(posedge sck) disable iff (!nrst) // see R7
		!hold_n && !fresh |=> $stable(l.ph) && $stable(l.osh) && $stable(l.addr))
		else $error("transfer moved while paused");

	a_bad_opcode: assert property (@(posedge sck) disable iff (!nrst) // see R18
		hold_n && !f_dead && f_ph == 3'h7 && f_nb == 3'h0 && !op_known(sh_in)
		|=> l.dead) else $error("unknown opcode not dropped");
endmodule // sec_core

/* File: rtl/sec_pkg.sv */
/*
 sec_pkg: opcodes, status layout, array geometry and timing for the
 serial eeprom front end. Assumes a 100 MHz core clock.
*/
package sec_pkg;
	localparam logic [7:0] OP_SET_WL  = 8'h06;
	localparam logic [7:0] OP_CLR_WL  = 8'h04;
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_READ    = 8'h03;
	localparam logic [7:0] OP_WRITE   = 8'h02;

	localparam int ST_LOCK  = 7;
	localparam int ST_BG_HI = 3;
	localparam int ST_BG_LO = 2;
	localparam int ST_WL    = 1;
	localparam int ST_BUSY  = 0;

	localparam int ADDR_W = 15;
	localparam int COL_W  = 6;
	localparam int PAGE_W = 9;
	localparam int GRP_W  = 4;
	localparam int WORD_W = 32;
	localparam int ECC_W  = 6;
	localparam int WORDS  = 8192;

	// bytes completed in a frame before each kind of commit, or before read data is driven
	localparam logic [2:0] NB_CTRL = 3'h1;
	localparam logic [2:0] NB_STAT = 3'h2;
	localparam logic [2:0] NB_HDR  = 3'h3;
	localparam logic [2:0] NB_DATA = 3'h4;

	localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

	localparam real PROGRAM_TIME_MS = 5.0;
	localparam real MCLK_MHZ        = 100.0;
	localparam int  PROGRAM_CYC     = $rtoi(PROGRAM_TIME_MS * 1000.0 * MCLK_MHZ);
	localparam int  TMR_W           = 20;
endpackage
